// >>> inc/bsx_pkg.sv
// Shared constants for the branch/skip/extension decode block
package bsx_pkg;
	localparam int DATA_W = 8;
	localparam int FSR_W = 12;
	localparam int FSR_CNT = 3;
	localparam int FSR_THIRD = 2;
	// Opcode fields
	localparam logic [7:0] OP_BR_OV_CLR = 8'hE5;
	localparam logic [7:0] OP_BR_Z_CLR = 8'hE1;
	localparam logic [5:0] OP_INC_SKIP_Z = 6'h0F;
	localparam logic [5:0] OP_INC_SKIP_NZ = 6'h12;
	localparam logic [7:0] OP_PTR_ADD = 8'hE8;
	localparam logic [7:0] OP_PTR_SUB = 8'hE9;
	localparam logic [7:0] OP_LIT_PUSH = 8'hEA;
	localparam logic [7:0] OP_IDX_MOVE = 8'hEB;
	localparam logic [15:0] OP_REG_CALL = 16'h0014;
	localparam logic [3:0] OP_SECOND_WORD = 4'hF;
	localparam logic [1:0] PTR_SEL_RET = 2'h3;
	// Other two-word opcodes that a skip must flush whole
	localparam logic [7:0] OP_GOTO = 8'hEF;
	localparam logic [7:0] OP_LOAD_PTR = 8'hEE;
	localparam logic [6:0] OP_CALL7 = 7'h76;
	localparam logic [3:0] OP_MOVE_FF = 4'hC;
	// Addressing
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	localparam logic [7:0] ACC_SPLIT = 8'h80;
	localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
	localparam logic [3:0] ACC_LOW_BANK = 4'h0;
	localparam logic [FSR_W-1:0] FSR_RST = 12'h000;
	localparam logic [7:0] W_RST = 8'h00;
	// Register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CALL_HI = 8'h04;
	localparam logic [7:0] REG_BANK = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0C;
	localparam logic [7:0] REG_WORK = 8'h10;
	localparam logic [7:0] REG_PTR2 = 8'h14;
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'b0;
	typedef enum logic [1:0] {
		ST_EXEC = 2'h0,
		ST_BUBBLE = 2'h1,
		ST_DISCARD = 2'h3,
		ST_SECOND = 2'h2
	} bsx_state_t;
endpackage : bsx_pkg

// >>> inc/bsx_reg_if.sv
// Control and status between the register slave and the core
`timescale 1ns/1ns
interface bsx_reg_if #(parameter int PC_W = 21);
	logic ext_en;
	logic run_en;
	logic [PC_W-9:0] call_hi;
	logic [3:0] bank;
	logic [PC_W-1:0] pc;
	logic [7:0] work;
	logic [11:0] ptr2;
	modport regs (output ext_en, run_en, call_hi, bank, input pc, work, ptr2);
	modport core (input ext_en, run_en, call_hi, bank, output pc, work, ptr2);
endinterface : bsx_reg_if

// >>> rtl/bsx_ahb_regs.sv
// AHB-Lite register slave for the decode block
`timescale 1ns/1ns
module bsx_ahb_regs
	import bsx_pkg::*;
#(
	parameter int PC_W = 21
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core side
	bsx_reg_if.regs rif
);
	logic ext_r, ext_nxt;
	logic run_r, run_nxt;
	logic [PC_W-9:0] call_hi_r, call_hi_nxt;
	logic [3:0] bank_r, bank_nxt;
	logic wr_r, wr_nxt;
	logic [7:0] wa_r, wa_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic take;

	always_comb
	begin
		take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
		ext_nxt = ext_r;
		run_nxt = run_r;
		call_hi_nxt = call_hi_r;
		bank_nxt = bank_r;
		if (wr_r)
		begin
			unique case (wa_r)
				REG_CTRL:
				begin
					ext_nxt = hwdata[CTRL_EXT_BIT];
					run_nxt = hwdata[CTRL_RUN_BIT];
				end
				REG_CALL_HI: call_hi_nxt = hwdata[PC_W-9:0];
				REG_BANK: bank_nxt = hwdata[3:0];
				default: ;
			endcase
		end
		wr_nxt = take && hwrite;
		wa_nxt = take ? haddr : wa_r;
		// Read value comes from next state so a write just before is seen
		rd_nxt = rd_r;
		if (take && !hwrite)
		begin
			rd_nxt = '0;
			unique case (haddr)
				REG_CTRL:
				begin
					rd_nxt[CTRL_EXT_BIT] = ext_nxt;
					rd_nxt[CTRL_RUN_BIT] = run_nxt;
				end
				REG_CALL_HI: rd_nxt[PC_W-9:0] = call_hi_nxt;
				REG_BANK: rd_nxt[3:0] = bank_nxt;
				REG_PC: rd_nxt[PC_W-1:0] = rif.pc;
				REG_WORK: rd_nxt[7:0] = rif.work;
				REG_PTR2: rd_nxt[11:0] = rif.ptr2;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ext_r <= 1'b0;
			run_r <= 1'b0;
			call_hi_r <= '0;
			bank_r <= '0;
			wr_r <= 1'b0;
			wa_r <= '0;
			rd_r <= '0;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
		else
		begin
			ext_r <= ext_nxt;
			run_r <= run_nxt;
			call_hi_r <= call_hi_nxt;
			bank_r <= bank_nxt;
			wr_r <= wr_nxt;
			wa_r <= wa_nxt;
			rd_r <= rd_nxt;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
		end
	end

	assign hrdata = rd_r;
	assign rif.ext_en = ext_r;
	assign rif.run_en = run_r;
	assign rif.call_hi = call_hi_r;
	assign rif.bank = bank_r;
endmodule : bsx_ahb_regs

// >>> rtl/bsx_core.sv
// Decode and execute of branches, increment-skips and the extended group
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
// Operation
// - Overflow-clear branch jumps to PC+2+2n
// - Offset is signed, doubled, added after advance
// - Taken branch adds one idle fetch cycle
// - Increment, skip next when result zero
// - Increment, skip next when result nonzero
// - Skipped word runs as no-operation
// - Destination bit picks work or file
// - Access bit picks access or banked
// - Extension: low access addresses index pointer two
// - Extension off after reset until enabled
// - Pointer add/subtract six-bit literal, one cycle
// - Pointer field three also returns, two cycles
// - Call through work register, two cycles
// - Two-word indexed moves, two cycles
// - Push literal at pointer two, decrement
module bsx_core
	import bsx_pkg::*;
#(
	parameter int PC_W = 21,
	parameter int ADDR_W = 12
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Program fetch
	output logic [PC_W-1:0] fetch_addr,
	input wire logic [15:0] instr,
	// Status flags from the status logic
	input wire logic ovf_flag,
	input wire logic zero_flag,
	// Return stack
	output logic ret_push,
	output logic [PC_W-1:0] ret_push_addr,
	output logic ret_pop,
	input wire logic [PC_W-1:0] ret_top,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	bsx_reg_if #(.PC_W(PC_W)) rif ();

	bsx_ahb_regs #(.PC_W(PC_W)) u_regs (
		.clk(clk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.rif(rif)
	);

	function automatic logic [ADDR_W-1:0] idx_addr(input logic [FSR_W-1:0] base, input logic [7:0] off);
		idx_addr = ADDR_W'(base + {4'h0, off});
	endfunction : idx_addr

	function automatic logic two_word(input logic [15:0] w);
		two_word = w[15:8] == OP_GOTO || w[15:8] == OP_LOAD_PTR || w[15:9] == OP_CALL7
			|| w[15:12] == OP_MOVE_FF || w[15:8] == OP_IDX_MOVE;
	endfunction : two_word

	bsx_state_t st_r, st_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [7:0] w_r, w_nxt;
	logic [FSR_W-1:0] fsr_r [FSR_CNT];
	logic [FSR_W-1:0] fsr_nxt [FSR_CNT];
	logic [ADDR_W-1:0] src_r, src_nxt;
	logic idx_dst_r, idx_dst_nxt;
	logic push_r, push_nxt;
	logic pop_r, pop_nxt;
	logic [PC_W-1:0] push_addr_r, push_addr_nxt;
	logic [7:0] mem [2**ADDR_W];
	logic mem_we;
	logic [ADDR_W-1:0] mem_wa;
	logic [7:0] mem_wd;
	logic [PC_W-1:0] pc_inc;
	logic [ADDR_W-1:0] fa;
	logic [7:0] inc_res;
	logic br_hit;
	logic [1:0] sel;
	logic [1:0] fi;
	logic [FSR_W-1:0] k6;

	always_comb
	begin
		st_nxt = st_r;
		pc_nxt = pc_r;
		w_nxt = w_r;
		fsr_nxt = fsr_r;
		src_nxt = src_r;
		idx_dst_nxt = idx_dst_r;
		push_nxt = 1'b0;
		pop_nxt = 1'b0;
		push_addr_nxt = push_addr_r;
		mem_we = 1'b0;
		mem_wa = '0;
		mem_wd = '0;
		pc_inc = PC_W'(pc_r + PC_W'(2));
		sel = instr[7:6];
		fi = (sel == PTR_SEL_RET) ? 2'(FSR_THIRD) : sel;
		k6 = {6'h00, instr[5:0]};
		if (instr[8])
			fa = {rif.bank, instr[7:0]};
		else if (rif.ext_en && instr[7:0] <= IDX_LIMIT)
			fa = idx_addr(fsr_r[FSR_THIRD], instr[7:0]);
		else if (instr[7:0] >= ACC_SPLIT)
			fa = {ACC_HIGH_BANK, instr[7:0]};
		else
			fa = {ACC_LOW_BANK, instr[7:0]};
		inc_res = 8'(mem[fa] + 8'h01);
		br_hit = (instr[15:8] == OP_BR_OV_CLR && !ovf_flag) || (instr[15:8] == OP_BR_Z_CLR && !zero_flag);
		if (rif.run_en)
		begin
			unique case (st_r)
				// idle cycle while target is fetched
				ST_BUBBLE: st_nxt = ST_EXEC;
				ST_DISCARD:
				begin
					pc_nxt = pc_inc;
					st_nxt = two_word(instr) ? ST_DISCARD : ST_EXEC;
				end
				ST_SECOND:
				begin
					pc_nxt = pc_inc;
					st_nxt = ST_EXEC;
					if (instr[15:12] == OP_SECOND_WORD)
					begin
						mem_we = 1'b1;
						mem_wa = idx_dst_r ? idx_addr(fsr_r[FSR_THIRD], {1'b0, instr[6:0]}) : instr[11:0];
						mem_wd = mem[src_r];
					end
				end
				ST_EXEC:
				begin
					pc_nxt = pc_inc;
					if (br_hit)
					begin
						pc_nxt = PC_W'(pc_inc + {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0});
						st_nxt = ST_BUBBLE;
					end
					else if (instr[15:10] == OP_INC_SKIP_Z || instr[15:10] == OP_INC_SKIP_NZ)
					begin
						if (instr[9])
						begin
							mem_we = 1'b1;
							mem_wa = fa;
							mem_wd = inc_res;
						end
						else
							w_nxt = inc_res;
						if ((inc_res == 8'h00) == (instr[15:10] == OP_INC_SKIP_Z))
							st_nxt = ST_DISCARD;
					end
					else if (rif.ext_en)
					begin
						if (instr[15:8] == OP_PTR_ADD || instr[15:8] == OP_PTR_SUB)
						begin
							fsr_nxt[fi] = (instr[15:8] == OP_PTR_ADD) ? FSR_W'(fsr_r[fi] + k6) : FSR_W'(fsr_r[fi] - k6);
							if (sel == PTR_SEL_RET)
							begin
								pc_nxt = ret_top;
								pop_nxt = 1'b1;
								st_nxt = ST_BUBBLE;
							end
						end
						else if (instr[15:8] == OP_LIT_PUSH)
						begin
							mem_we = 1'b1;
							mem_wa = idx_addr(fsr_r[FSR_THIRD], 8'h00);
							mem_wd = instr[7:0];
							fsr_nxt[FSR_THIRD] = FSR_W'(fsr_r[FSR_THIRD] - FSR_W'(1));
						end
						else if (instr[15:8] == OP_IDX_MOVE)
						begin
							src_nxt = idx_addr(fsr_r[FSR_THIRD], {1'b0, instr[6:0]});
							idx_dst_nxt = instr[7];
							st_nxt = ST_SECOND;
						end
						else if (instr == OP_REG_CALL)
						begin
							push_nxt = 1'b1;
							push_addr_nxt = pc_inc;
							pc_nxt = {rif.call_hi, w_r};
							st_nxt = ST_BUBBLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= ST_EXEC;
			pc_r <= '0;
			w_r <= W_RST;
			for (int i = 0; i < FSR_CNT; i++)
				fsr_r[i] <= FSR_RST;
			src_r <= '0;
			idx_dst_r <= 1'b0;
			push_r <= 1'b0;
			pop_r <= 1'b0;
			push_addr_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			pc_r <= pc_nxt;
			w_r <= w_nxt;
			fsr_r <= fsr_nxt;
			src_r <= src_nxt;
			idx_dst_r <= idx_dst_nxt;
			push_r <= push_nxt;
			pop_r <= pop_nxt;
			push_addr_r <= push_addr_nxt;
		end
	end

	// Data memory holds no reset; software must initialise what it reads
	always_ff @(posedge clk)
	begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end

	assign fetch_addr = pc_r;
	assign ret_push = push_r;
	assign ret_push_addr = push_addr_r;
	assign ret_pop = pop_r;
	assign rif.pc = pc_r;
	assign rif.work = w_r;
	assign rif.ptr2 = fsr_r[FSR_THIRD];
endmodule : bsx_core

// >>> sim/bsx_core_sva.sv
// Concurrent checks on the decode block's top ports
`timescale 1ns/1ns
module bsx_core_sva
	import bsx_pkg::*;
#(
	parameter int PC_W = 21
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Core
	input wire logic [PC_W-1:0] fetch_addr,
	input wire logic [15:0] instr,
	input wire logic ovf_flag,
	input wire logic zero_flag,
	input wire logic ret_push,
	input wire logic [PC_W-1:0] ret_push_addr,
	input wire logic ret_pop,
	input wire logic [PC_W-1:0] ret_top,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	logic wr_r, wr_nxt, mc_r, mc_nxt, ex;
	logic [1:0] ctl_r, ctl_nxt;
	logic [PC_W-1:0] nx, tgt;
	assign ex = ctl_r[1] && !mc_r;
	assign nx = fetch_addr + PC_W'(2);
	assign tgt = nx + {{(PC_W-9){instr[7]}}, instr[7:0], 1'b0};
	// Conservative: any op that may cost a spare cycle masks the next one
	always_comb
	begin
		wr_nxt = hsel && hready && htrans[1] && hwrite && haddr == REG_CTRL;
		ctl_nxt = wr_r ? hwdata[1:0] : ctl_r;
		mc_nxt = ex && (instr[15:11] == 5'h1C || instr[15:9] == 7'h74 || instr[15:8] == OP_IDX_MOVE
			|| instr == OP_REG_CALL || instr[15:10] == OP_INC_SKIP_Z || instr[15:10] == OP_INC_SKIP_NZ);
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_r <= 1'b0;
			mc_r <= 1'b0;
			ctl_r <= 2'h0;
		end
		else
		begin
			wr_r <= wr_nxt;
			mc_r <= mc_nxt;
			ctl_r <= ctl_nxt;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	br_ovf_a: assert property (ex && instr[15:8] == OP_BR_OV_CLR && !ovf_flag
		|=> fetch_addr == $past(tgt) ##1 $stable(fetch_addr)) else $error("overflow branch target");
	br_zero_a: assert property (ex && instr[15:8] == OP_BR_Z_CLR && !zero_flag
		|=> fetch_addr == $past(tgt) ##1 $stable(fetch_addr)) else $error("zero branch target");
	br_fall_a: assert property (ex && (instr[15:8] == OP_BR_OV_CLR && ovf_flag
		|| instr[15:8] == OP_BR_Z_CLR && zero_flag) |=> fetch_addr == $past(nx)) else $error("branch fall");
	skip_step_a: assert property (ex && (instr[15:10] == OP_INC_SKIP_Z
		|| instr[15:10] == OP_INC_SKIP_NZ) |=> fetch_addr == $past(nx)) else $error("skip step");
	call_w_a: assert property (ex && ctl_r[0] && instr == OP_REG_CALL
		|=> ret_push && ret_push_addr == $past(nx) ##1 !ret_push && $stable(fetch_addr)) else $error("call");
	ptr_ret_a: assert property (ex && ctl_r[0] && instr[15:9] == 7'h74 && instr[7:6] == PTR_SEL_RET
		|=> ret_pop && fetch_addr == $past(ret_top) ##1 !ret_pop) else $error("pointer return");
	ptr_one_a: assert property (ex && ctl_r[0] && (instr[15:9] == 7'h74 && instr[7:6] != PTR_SEL_RET
		|| instr[15:8] == OP_LIT_PUSH) |=> fetch_addr == $past(nx) && !ret_pop) else $error("one cycle op");
	ext_off_a: assert property (ex && !ctl_r[0] && (instr[15:10] == 6'h3A || instr == OP_REG_CALL)
		|=> fetch_addr == $past(nx) && !ret_push && !ret_pop) else $error("extension off");
	run_hold_a: assert property (!ctl_r[1] |=> $stable(fetch_addr)) else $error("advance while stopped");
	bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY) else $error("bus not ready or not okay");
	cover property (ret_push);
	cover property (ret_pop);
	cover property (ex && instr[15:8] == OP_BR_Z_CLR && !zero_flag);
endmodule : bsx_core_sva

// >>> sim/tb_top.sv
// Self-checking bench for the branch, skip and extension decode block
`timescale 1ns/1ns
module tb_top;
	import bsx_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic ovf_flag = 1'b0;
	logic zero_flag = 1'b0;
	logic dph = 1'b0;
	logic hready, hreadyout, hresp, ret_push, ret_pop;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, hi;
	logic [20:0] fetch_addr, ret_push_addr;
	logic [20:0] ret_top = 21'h0_0008;
	logic [15:0] instr;
	logic [15:0] pm [0:127];
	logic [7:0] op, oth;
	logic [39:0] nt;
	logic [39:0] q [$];
	int n_fail = 0;
	int compares = 0;
	int seed = 19225;
	always #20 clk = ~clk;
	assign hready = hreadyout;
	// Upper program space folds onto the top half of the table
	assign instr = pm[{|fetch_addr[20:7], fetch_addr[6:1]}];
	bsx_core u_dut (.*);
	always @(posedge clk)
	begin
		if (dph)
		begin
			nt = q.pop_front();
			compares++;
			if (hrdata !== nt[31:0])
			begin
				$display("MISMATCH reg %h exp %h got %h", nt[39:32], nt[31:0], hrdata);
				n_fail++;
			end
		end
		dph <= hsel && hready && htrans[1] && !hwrite;
	end
	task results;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task rdy;
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (hready !== 1'b1 && i < 16);
		if (hready !== 1'b1)
		begin
			n_fail++;
			results;
		end
	endtask : rdy
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		if (!w)
			q.push_back({a, d});
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
	endtask : xfer
	task fresh;
		rst <= 1'b1;
		for (int i = 0; i < 128; i++)
			pm[i] = 16'h0000;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : fresh
	// Programs end in a branch onto itself, so the stop point is exact
	task run(input logic e);
		xfer(1'b1, REG_CTRL, {30'h0, 1'b1, e});
		repeat (40) @(posedge clk);
		xfer(1'b1, REG_CTRL, {31'h0, e});
	endtask : run
	task chk(input logic [31:0] pc, input logic [31:0] w, input logic [31:0] p);
		xfer(1'b0, REG_PC, pc);
		xfer(1'b0, REG_WORK, w);
		xfer(1'b0, REG_PTR2, p);
	endtask : chk
	initial
	begin
		fresh;
		xfer(1'b1, REG_PC, 32'hFFFF_FFFF);
		xfer(1'b0, REG_PC, 32'h0000_0000);
		xfer(1'b0, REG_CTRL, 32'h0000_0000);
		xfer(1'b1, REG_BANK, 32'h0000_00A7);
		xfer(1'b0, REG_BANK, 32'h0000_0007);
		xfer(1'b0, 8'h20, 32'h0000_0000);
		$display("test registers done");
		for (int t = 0; t < 4; t++)
		begin
			fresh;
			op = t[0] ? OP_BR_Z_CLR : OP_BR_OV_CLR;
			oth = t[0] ? OP_BR_OV_CLR : OP_BR_Z_CLR;
			pm[0] = {op, 8'h03};
			pm[1] = {oth, 8'hFF};
			pm[2] = {oth, 8'hFF};
			pm[4] = {op, 8'hFD};
			ovf_flag <= t[1] && !t[0];
			zero_flag <= t[1] && t[0];
			run(1'b0);
			chk(t[1] ? 32'h0000_0002 : 32'h0000_0004, 32'h0000_0000, 32'h0000_0000);
		end
		$display("test branches done");
		fresh;
		ovf_flag <= 1'b0;
		zero_flag <= 1'b0;
		pm[0] = 16'hE885;
		pm[1] = 16'hEAFF;
		pm[2] = 16'h3F05;
		pm[3] = 16'hEF00;
		pm[4] = 16'hF000;
		pm[5] = 16'h4801;
		pm[6] = 16'hE5FF;
		pm[7] = 16'hE5FF;
		run(1'b1);
		chk(32'h0000_000E, 32'h0000_0001, 32'h0000_0004);
		$display("test skips done");
		// Moves into a banked and an indexed cell, then read both back through increments
		fresh;
		xfer(1'b1, REG_BANK, 32'h0000_0001);
		pm[0] = 16'hE884;
		pm[1] = 16'hEA3C;
		pm[2] = 16'hEB01;
		pm[3] = 16'hF120;
		pm[4] = 16'hEB81;
		pm[5] = 16'hF002;
		pm[6] = 16'h3D20;
		pm[7] = 16'h4A02;
		pm[8] = 16'hE881;
		pm[9] = 16'hE5FF;
		run(1'b1);
		chk(32'h0000_0012, 32'h0000_003D, 32'h0000_0003);
		$display("test moves done");
		for (int e = 0; e < 2; e++)
		begin
			fresh;
			hi = $random(seed) & 32'h0000_1FFF | 32'h0000_0001;
			xfer(1'b1, REG_CALL_HI, hi);
			xfer(1'b0, REG_CALL_HI, hi);
			pm[0] = 16'hE883;
			pm[1] = 16'hE981;
			pm[2] = 16'hEA55;
			pm[3] = 16'hE8C5;
			pm[4] = OP_REG_CALL;
			pm[5] = 16'hE5FF;
			pm[64] = 16'hE5FF;
			run(e[0]);
			chk(e ? hi << 8 : 32'h0000_000A, 32'h0000_0000, e ? 32'h0000_0006 : 32'h0000_0000);
		end
		$display("test extension done");
		results;
	end
endmodule : tb_top
bind bsx_core bsx_core_sva #(.PC_W(PC_W)) u_sva (.*);
